// ==== core/aux_pin_pkg.sv ====
// Package for the auxiliary pin control block.
// Assumes a single 250 MHz clock and a simple strobe register port.
package aux_pin_pkg;

	// ==========================================================
	// Sizes
	localparam int NUM_REG  = 11;
	localparam int ADDR_W   = 4;
	localparam int DATA_W   = 32;
	localparam int VCODE_W  = 4;

	// ==========================================================
	// Register offsets (word index on the strobe port)
	localparam logic [ADDR_W-1:0] OFF_GPO_CTRL   = 4'h0;
	localparam logic [ADDR_W-1:0] OFF_GOOD_MEMB  = 4'h1;
	localparam logic [ADDR_W-1:0] OFF_SEC_CTRL   = 4'h2;
	localparam logic [ADDR_W-1:0] OFF_PIN_STATUS = 4'h3;
	localparam logic [ADDR_W-1:0] OFF_SAFE_SEL   = 4'h4;
	localparam logic [ADDR_W-1:0] OFF_SAFE_FLAGS = 4'h5;
	localparam logic [ADDR_W-1:0] OFF_RANDOM     = 4'h6;
	localparam logic [ADDR_W-1:0] OFF_CHECK      = 4'h7;
	localparam logic [ADDR_W-1:0] OFF_REG_LIVE   = 4'h8;
	localparam logic [ADDR_W-1:0] OFF_REG_LATCH  = 4'h9;

	// ==========================================================
	// Field positions
	localparam int B_RUN_LVL   = 0;
	localparam int B_STBY_LVL  = 1;
	localparam int B_VSEL_EN   = 0;
	localparam int B_HW_EN     = 1;
	localparam int B_RUN_EN    = 2;
	localparam int B_STBY_EN   = 3;
	localparam int F_RUN_V_LO  = 4;
	localparam int F_STBY_V_LO = 8;
	localparam int B_SECURE    = 12;
	localparam int B_VSEL_S    = 0;
	localparam int B_EN_S      = 1;
	localparam int B_SAFE_S    = 2;
	localparam int B_GOOD_S    = 3;
	localparam int LIVE_UV_LO  = 16;

	// ==========================================================
	// Voltage codes and reset values
	localparam logic [VCODE_W-1:0] VCODE_3V3 = 4'hF;
	localparam logic [VCODE_W-1:0] VCODE_1V8 = 4'h8;
	localparam logic [DATA_W-1:0]  RST_ZERO  = 32'h0000_0000;
	localparam logic [7:0] RANDOM_SEED = 8'hA5;

	// Safety flags, bit order in the flag register
	typedef struct packed {
		logic hard_fault;
		logic watchdog_counter;
		logic external_watchdog;
		logic soft_fault;
	} safe_flags_t;

	// Fault events from the rest of the chip
	typedef struct packed {
		logic current_limit_fault;
		logic external_watchdog_reset;
		logic watchdog_counter_reset;
		logic fault_timer_expired;
		logic regulator_fault_max;
		logic watchdog_event_max;
		logic power_up_failure;
		logic thermal_shutdown;
	} fault_events_t;

	typedef enum logic [1:0] {
		SEC_IDLE,
		SEC_CLEARED,
		SEC_RANDOM_READ
	} secure_state_t;

endpackage : aux_pin_pkg

// ==== core/pmic_aux_pin_control.sv ====
// Auxiliary pin control: power-good/GPO, secondary regulator select and
// enable, safety output with fault safe state mode fused off.
// Assumes fuse bits stable, state inputs from the chip sequencer on sys_clk,
// and pins that arrive asynchronously.
//
// Function
// [RQ1] Fused mode 0 makes power good a GPO
// [RQ2] GPO in run follows run level bit
// [RQ3] GPO in standby follows standby level bit
// [RQ4] Power-up loads both level bits from fuse
// [RQ5] Fused mode 1 ANDs selected monitors
// [RQ6] Membership bit includes or excludes monitor
// [RQ7] Fault pulls pin low, latch holds
// [RQ8] Disabled regulator excluded from the AND
// [RQ9] Hold low, masked until reset releases
// [RQ10] Select pin picks 3.3 or 1.8 code
// [RQ11] Select disabled uses run voltage field
// [RQ12] Standby always uses standby voltage field
// [RQ13] Status bit mirrors select pin level
// [RQ14] Status bit mirrors enable pin level
// [RQ15] Hardware control gates enable with pin
// [RQ16] Safety output active low, normally high
// [RQ17] Fault safe mode: only selected sources; code clears all flags while fused_safe_state_mode is set
// [RQ18] Secure clear: W1C, random read, check
// [RQ19] Soft faults set sticky flag if selected
// [RQ20] External watchdog reset sets flag if selected
// [RQ21] Counter watchdog reset sets flag if selected
// [RQ22] Hard shutdowns set flag if selected
// [RQ23] Release when flags clear or supply low
`timescale 1ns/1ps

module pmic_aux_pin_control
	import aux_pin_pkg::*;
#(
	parameter int NUM_REGS = NUM_REG
) (
	input  wire logic                sys_clk,
	input  wire logic                rst,
	input  wire logic [ADDR_W-1:0]   reg_addr,
	input  wire logic [DATA_W-1:0]   reg_wdata,
	input  wire logic                reg_wr,
	input  wire logic                reg_rd,
	output logic      [DATA_W-1:0]   reg_rdata,
	input  wire logic                fused_power_good_mode,
	input  wire logic                fused_indicator_sequence_slot,
	input  wire logic                fused_voltage_select_enable,
	input  wire logic                fused_hardware_enable_control,
	input  wire logic                fused_safe_state_mode,
	input  wire logic                run_state,
	input  wire logic                standby_state,
	input  wire logic                power_up_load,
	input  wire logic                processor_reset_ready,
	input  wire logic [NUM_REGS-1:0] regulator_enabled,
	input  wire logic [NUM_REGS-1:0] overvoltage_live_status,
	input  wire logic [NUM_REGS-1:0] undervoltage_live_status,
	input  wire fault_events_t       fault_events,
	input  wire logic                below_input_undervoltage_threshold,
	input  wire logic                voltage_select_pin,
	input  wire logic                secondary_enable_pin,
	output logic                     power_good_pin_o,
	output logic                     power_good_pin_oe,
	output logic                     safety_output_n_o,
	output logic                     safety_output_n_oe,
	output logic [VCODE_W-1:0]       secondary_voltage_code,
	output logic                     secondary_linear_regulator_en,
	output logic                     fault_protection_req
);

	// ==========================================================
	// Pin synchronisers
	logic [1:0] vsel_sync;
	logic [1:0] en_sync;
	logic [1:0] next_vsel_sync;
	logic [1:0] next_en_sync;
	logic       vsel_level;
	logic       en_level;

	always_comb begin
		next_vsel_sync = {vsel_sync[0], voltage_select_pin};
		next_en_sync   = {en_sync[0], secondary_enable_pin};
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			vsel_sync <= 2'b00;
			en_sync   <= 2'b00;
		end else begin
			vsel_sync <= next_vsel_sync;
			en_sync   <= next_en_sync;
		end
	end

	assign vsel_level = vsel_sync[1];
	assign en_level   = en_sync[1];

	// ==========================================================
	// Control registers
	logic                run_output_level;
	logic                standby_output_level;
	logic [NUM_REGS-1:0] good_member_enable;
	logic                voltage_select_enable;
	logic                hardware_enable_control;
	logic                secondary_run_enable;
	logic                secondary_standby_enable;
	logic [VCODE_W-1:0]  run_vfield;
	logic [VCODE_W-1:0]  stby_vfield;
	logic                secure_write_enable;
	safe_flags_t         safe_select;
	logic                next_run_output_level;
	logic                next_standby_output_level;
	logic [NUM_REGS-1:0] next_good_member_enable;
	logic                next_voltage_select_enable;
	logic                next_hardware_enable_control;
	logic                next_secondary_run_enable;
	logic                next_secondary_standby_enable;
	logic [VCODE_W-1:0]  next_run_vfield;
	logic [VCODE_W-1:0]  next_stby_vfield;
	logic                next_secure_write_enable;
	safe_flags_t         next_safe_select;
	logic                fuse_load_done;
	logic                next_fuse_load_done;

	always_comb begin
		next_run_output_level         = run_output_level;
		next_standby_output_level     = standby_output_level;
		next_good_member_enable       = good_member_enable;
		next_voltage_select_enable    = voltage_select_enable;
		next_hardware_enable_control  = hardware_enable_control;
		next_secondary_run_enable     = secondary_run_enable;
		next_secondary_standby_enable = secondary_standby_enable;
		next_run_vfield               = run_vfield;
		next_stby_vfield              = stby_vfield;
		next_secure_write_enable      = secure_write_enable;
		next_safe_select              = safe_select;
		next_fuse_load_done           = 1'b1;
		// Fuse defaults caught once after reset release
		if (!fuse_load_done) begin
			next_voltage_select_enable   = fused_voltage_select_enable;
			next_hardware_enable_control = fused_hardware_enable_control;
		end
		if (power_up_load) begin
			next_run_output_level     = fused_indicator_sequence_slot; // [RQ4]
			next_standby_output_level = fused_indicator_sequence_slot; // [RQ4]
		end else if (reg_wr && reg_addr == OFF_GPO_CTRL) begin
			next_run_output_level     = reg_wdata[B_RUN_LVL];
			next_standby_output_level = reg_wdata[B_STBY_LVL];
		end
		if (reg_wr && reg_addr == OFF_GOOD_MEMB)
			next_good_member_enable = reg_wdata[NUM_REGS-1:0];
		if (reg_wr && reg_addr == OFF_SEC_CTRL) begin
			next_voltage_select_enable    = reg_wdata[B_VSEL_EN];
			next_hardware_enable_control  = reg_wdata[B_HW_EN];
			next_secondary_run_enable     = reg_wdata[B_RUN_EN];
			next_secondary_standby_enable = reg_wdata[B_STBY_EN];
			next_run_vfield  = reg_wdata[F_RUN_V_LO +: VCODE_W];
			next_stby_vfield = reg_wdata[F_STBY_V_LO +: VCODE_W];
			next_secure_write_enable      = reg_wdata[B_SECURE];
		end
		if (reg_wr && reg_addr == OFF_SAFE_SEL)
			next_safe_select = safe_flags_t'(reg_wdata[3:0]);
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			run_output_level         <= 1'b0;
			standby_output_level     <= 1'b0;
			good_member_enable       <= '0;
			voltage_select_enable    <= 1'b0;
			hardware_enable_control  <= 1'b0;
			secondary_run_enable     <= 1'b0;
			secondary_standby_enable <= 1'b0;
			run_vfield               <= '0;
			stby_vfield              <= '0;
			secure_write_enable      <= 1'b0;
			safe_select              <= '0;
			fuse_load_done           <= 1'b0;
		end else begin
			run_output_level         <= next_run_output_level;
			standby_output_level     <= next_standby_output_level;
			good_member_enable       <= next_good_member_enable;
			voltage_select_enable    <= next_voltage_select_enable;
			hardware_enable_control  <= next_hardware_enable_control;
			secondary_run_enable     <= next_secondary_run_enable;
			secondary_standby_enable <= next_secondary_standby_enable;
			run_vfield               <= next_run_vfield;
			stby_vfield              <= next_stby_vfield;
			secure_write_enable      <= next_secure_write_enable;
			safe_select              <= next_safe_select;
			fuse_load_done           <= next_fuse_load_done;
		end
	end

	// ==========================================================
	// Power good monitors
	logic [NUM_REGS-1:0] member_ok;
	logic [NUM_REGS-1:0] reg_latch;
	logic [NUM_REGS-1:0] next_reg_latch;
	logic                all_good;
	logic                unmasked;
	logic                next_unmasked;
	logic                good_level;
	logic                next_good_level;
	logic                next_protect;

	genvar gi;
	generate
		for (gi = 0; gi < NUM_REGS; gi++) begin : g_mon
			// Excluded unless member and enabled
			assign member_ok[gi] = !(good_member_enable[gi] // [RQ6]
				&& regulator_enabled[gi] // [RQ8]
				&& (overvoltage_live_status[gi]
				|| undervoltage_live_status[gi]));
		end
	endgenerate

	assign all_good = &member_ok; // [RQ5]

	always_comb begin
		next_reg_latch = reg_latch;
		if (reg_wr && reg_addr == OFF_REG_LATCH)
			next_reg_latch = reg_latch & ~reg_wdata[NUM_REGS-1:0];
		// Set beats a clear in the same cycle
		next_reg_latch = next_reg_latch | ~member_ok; // [RQ7]
		next_unmasked  = unmasked;
		next_protect   = 1'b0;
		if (!run_state && !standby_state)
			next_unmasked = 1'b0; // [RQ9]
		else if (processor_reset_ready && !unmasked) begin
			next_unmasked = 1'b1; // [RQ9]
			next_protect  = !all_good; // [RQ9]
		end
		if (!fused_power_good_mode) begin // [RQ1]
			if (standby_state)
				next_good_level = standby_output_level; // [RQ3]
			else if (run_state)
				next_good_level = run_output_level; // [RQ2]
			else
				next_good_level = 1'b0;
		end else
			next_good_level = next_unmasked && all_good; // [RQ5] [RQ7]
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			reg_latch            <= '0;
			unmasked             <= 1'b0;
			good_level           <= 1'b0;
			fault_protection_req <= 1'b0;
		end else begin
			reg_latch            <= next_reg_latch;
			unmasked             <= next_unmasked;
			good_level           <= next_good_level;
			fault_protection_req <= next_protect;
		end
	end

	// Open drain: drive only the low level
	assign power_good_pin_o  = 1'b0;
	assign power_good_pin_oe = !good_level;

	// ==========================================================
	// Secondary regulator select and enable
	logic [VCODE_W-1:0] next_vcode;
	logic               next_sec_en;

	always_comb begin
		if (standby_state) begin
			next_vcode = stby_vfield; // [RQ12]
			next_sec_en = secondary_standby_enable;
		end else begin
			if (voltage_select_enable)
				next_vcode = vsel_level ? VCODE_1V8 : VCODE_3V3; // [RQ10]
			else
				next_vcode = run_vfield; // [RQ11]
			next_sec_en = secondary_run_enable;
		end
		if (hardware_enable_control)
			next_sec_en = next_sec_en && en_level; // [RQ15]
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			secondary_voltage_code        <= '0;
			secondary_linear_regulator_en <= 1'b0;
		end else begin
			secondary_voltage_code        <= next_vcode;
			secondary_linear_regulator_en <= next_sec_en;
		end
	end

	// ==========================================================
	// Safety output flags and secure clear
	safe_flags_t   flags;
	safe_flags_t   next_flags;
	safe_flags_t   pending_clear;
	safe_flags_t   next_pending_clear;
	safe_flags_t   events;
	secure_state_t sec_state;
	secure_state_t next_sec_state;
	logic [7:0]    random_value;
	logic [7:0]    next_random_value;
	logic          soft_event;
	logic          hard_event;
	logic          next_safe_asserted;
	logic          safe_asserted;

	assign soft_event = (|overvoltage_live_status)
		|| (|undervoltage_live_status)
		|| fault_events.current_limit_fault;
	assign hard_event = fault_events.fault_timer_expired
		|| fault_events.regulator_fault_max
		|| fault_events.watchdog_event_max
		|| fault_events.power_up_failure
		|| fault_events.thermal_shutdown;

	always_comb begin
		events.soft_fault        = safe_select.soft_fault
			&& soft_event; // [RQ19]
		events.external_watchdog = safe_select.external_watchdog
			&& fault_events.external_watchdog_reset; // [RQ20]
		events.watchdog_counter  = safe_select.watchdog_counter
			&& fault_events.watchdog_counter_reset; // [RQ21]
		events.hard_fault        = safe_select.hard_fault
			&& hard_event; // [RQ22]
		next_flags         = flags;
		next_pending_clear = pending_clear;
		next_sec_state     = sec_state;
		next_random_value  = {random_value[6:0],
			random_value[7] ^ random_value[5]};
		if (reg_wr && reg_addr == OFF_SAFE_FLAGS) begin
			if (!secure_write_enable)
				next_flags = flags & ~safe_flags_t'(reg_wdata[3:0]);
			else begin
				next_pending_clear = safe_flags_t'(reg_wdata[3:0]); // [RQ18]
				next_sec_state     = SEC_CLEARED;
			end
		end else if (reg_rd && reg_addr == OFF_RANDOM) begin
			next_sec_state = (sec_state == SEC_CLEARED)
				? SEC_RANDOM_READ : SEC_IDLE; // [RQ18]
		end else if (reg_wr && reg_addr == OFF_CHECK) begin
			if (sec_state == SEC_RANDOM_READ
				&& reg_wdata[7:0] == random_value)
				next_flags = flags & ~pending_clear; // [RQ18]
			next_sec_state = SEC_IDLE;
		end else if (reg_wr || reg_rd)
			next_sec_state = SEC_IDLE;
		// Frozen from the read edge on, so the check sees what was read
		if (next_sec_state == SEC_RANDOM_READ)
			next_random_value = random_value;
		if (fused_safe_state_mode)
			next_flags = '0;
		else
			next_flags = next_flags | events; // [RQ17]
		next_safe_asserted = (|next_flags)
			&& !below_input_undervoltage_threshold; // [RQ23]
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			flags         <= '0;
			pending_clear <= '0;
			sec_state     <= SEC_IDLE;
			random_value  <= RANDOM_SEED;
			safe_asserted <= 1'b0;
		end else begin
			flags         <= next_flags;
			pending_clear <= next_pending_clear;
			sec_state     <= next_sec_state;
			random_value  <= next_random_value;
			safe_asserted <= next_safe_asserted;
		end
	end

	assign safety_output_n_o  = 1'b0; // [RQ16]
	assign safety_output_n_oe = safe_asserted; // [RQ16]

	// ==========================================================
	// Read port
	logic [DATA_W-1:0] next_rdata;

	always_comb begin
		next_rdata = RST_ZERO;
		if (reg_rd) begin
			unique case (reg_addr)
				OFF_GPO_CTRL: begin
					next_rdata[B_RUN_LVL]  = run_output_level;
					next_rdata[B_STBY_LVL] = standby_output_level;
				end
				OFF_GOOD_MEMB:  next_rdata[NUM_REGS-1:0] = good_member_enable;
				OFF_SEC_CTRL: begin
					next_rdata[B_VSEL_EN] = voltage_select_enable;
					next_rdata[B_HW_EN]   = hardware_enable_control;
					next_rdata[B_RUN_EN]  = secondary_run_enable;
					next_rdata[B_STBY_EN] = secondary_standby_enable;
					next_rdata[F_RUN_V_LO +: VCODE_W]  = run_vfield;
					next_rdata[F_STBY_V_LO +: VCODE_W] = stby_vfield;
					next_rdata[B_SECURE]  = secure_write_enable;
				end
				OFF_PIN_STATUS: begin
					next_rdata[B_VSEL_S] = vsel_level; // [RQ13]
					next_rdata[B_EN_S]   = en_level; // [RQ14]
					next_rdata[B_SAFE_S] = safe_asserted;
					next_rdata[B_GOOD_S] = good_level;
				end
				OFF_SAFE_SEL:   next_rdata[3:0] = safe_select;
				OFF_SAFE_FLAGS: next_rdata[3:0] = flags;
				OFF_RANDOM:     next_rdata[7:0] = random_value;
				OFF_REG_LIVE: begin
					next_rdata[NUM_REGS-1:0] = overvoltage_live_status;
					next_rdata[LIVE_UV_LO +: NUM_REGS] =
						undervoltage_live_status;
				end
				OFF_REG_LATCH:  next_rdata[NUM_REGS-1:0] = reg_latch;
				default:        next_rdata = RST_ZERO;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst)
			reg_rdata <= RST_ZERO;
		else
			reg_rdata <= next_rdata;
	end

	// ==========================================================
	// Checks
	a_gpo_run_level: assert property (@(posedge sys_clk) disable iff (rst) // [RQ2]
		!fused_power_good_mode && run_state && !standby_state
		|=> good_level == $past(run_output_level))
		else $error("GPO run level wrong");
	a_gpo_stby_level: assert property (@(posedge sys_clk) disable iff (rst) // [RQ3]
		!fused_power_good_mode && standby_state
		|=> good_level == $past(standby_output_level))
		else $error("GPO standby level wrong");
	a_pg_fault_low: assert property (@(posedge sys_clk) disable iff (rst) // [RQ7]
		fused_power_good_mode && !all_good |=> !good_level)
		else $error("Power good high during fault");
	a_pg_latch_hold: assert property (@(posedge sys_clk) disable iff (rst) // [RQ7]
		!member_ok[0] |=> reg_latch[0])
		else $error("Regulator fault not latched");
	a_vsel_code: assert property (@(posedge sys_clk) disable iff (rst) // [RQ10]
		voltage_select_enable && !standby_state
		|=> secondary_voltage_code
			== ($past(vsel_level) ? VCODE_1V8 : VCODE_3V3))
		else $error("Select code wrong");
	a_stby_code: assert property (@(posedge sys_clk) disable iff (rst) // [RQ12]
		standby_state |=> secondary_voltage_code == $past(stby_vfield))
		else $error("Standby code wrong");
	a_hw_enable: assert property (@(posedge sys_clk) disable iff (rst) // [RQ15]
		hardware_enable_control && !en_level |=> !secondary_linear_regulator_en)
		else $error("Regulator on with pin low");
	a_soft_flag: assert property (@(posedge sys_clk) disable iff (rst) // [RQ19]
		!fused_safe_state_mode && events.soft_fault
		|=> flags.soft_fault ##1 (flags.soft_fault || $past(reg_wr)))
		else $error("Soft fault flag not sticky");
	a_hard_flag: assert property (@(posedge sys_clk) disable iff (rst) // [RQ22]
		!fused_safe_state_mode && events.hard_fault
		&& !below_input_undervoltage_threshold |=> safety_output_n_oe)
		else $error("Hard fault did not assert output");
	a_release_clear: assert property (@(posedge sys_clk) disable iff (rst) // [RQ23]
		flags == '0 |-> !safety_output_n_oe)
		else $error("Safety output held with no flag");
	a_secure_order: assert property (@(posedge sys_clk) disable iff (rst) // [RQ18]
		secure_write_enable && sec_state != SEC_RANDOM_READ
		&& !fused_safe_state_mode |=> flags == ($past(flags) | $past(events)))
		else $error("Flag cleared outside secure order");

endmodule : pmic_aux_pin_control

// ==== dv/host.sv ====
// Host processor model: register port master and pin pull-ups.
// Assumes the block answers every read in the following cycle.
`timescale 1ns/1ps

module host
	import aux_pin_pkg::*;
(
	input  wire logic              sys_clk,
	input  wire logic              pg_oe,
	input  wire logic              so_oe,
	input  wire logic [DATA_W-1:0] reg_rdata,
	output logic      [ADDR_W-1:0] reg_addr,
	output logic      [DATA_W-1:0] reg_wdata,
	output logic                   reg_wr,
	output logic                   reg_rd,
	output logic                   pg_level,
	output logic                   so_level
);
	// ==========================================================
	// Open-drain pins, pulled up unless the device sinks them
	assign pg_level = !pg_oe;
	assign so_level = !so_oe;

	initial begin
		reg_addr = '0;
		reg_wdata = '0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end

	// ==========================================================
	// Bus cycles
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		// Data stands for this one cycle only
		#1 d = reg_rdata;
		// Hand back on a rising edge so the bench drives on the edge
		@(posedge sys_clk);
	endtask : rd

	// W1C, then random read, then check write, nothing between
	task automatic secure_clear(input logic [DATA_W-1:0] m);
		logic [DATA_W-1:0] r;
		wr(OFF_SAFE_FLAGS, m);
		rd(OFF_RANDOM, r);
		wr(OFF_CHECK, {24'h0, r[7:0]});
	endtask : secure_clear
endmodule : host

// ==== dv/test_pmic_aux_pin_control.sv ====
// Testbench for the auxiliary pin control block.
// Assumes the host model drives the register port and the pull-ups.
`timescale 1ns/1ps

module test_pmic_aux_pin_control
	import aux_pin_pkg::*;
;
	logic                sys_clk, rst, mode, slot, run_st, stby_st;
	logic                pul, rdy, below, sel_pin, en_pin, pg_oe, so_oe;
	logic                pg_level, so_level, reg_wr, reg_rd, ldo_en, prot;
	logic [ADDR_W-1:0]   reg_addr;
	logic [DATA_W-1:0]   reg_wdata, reg_rdata, d;
	logic [NUM_REG-1:0]  ena, ov;
	logic [VCODE_W-1:0]  code;
	fault_events_t       ev;
	int                  n_errors, total_checks;
	// Row: ctrl[19:8], standby, select pin, enable pin, code, enable
	logic [19:0]         rows [6] = '{20'h5_351F, 20'h5_3551, 20'h5_3606,
	                                  20'h5_3627, 20'h5_398B, 20'h5_35CA};
	int                  evb [4] = '{7, 6, 5, 0};

	pmic_aux_pin_control u_pmic_aux_pin_control (
		.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .fused_power_good_mode(mode),
		.fused_indicator_sequence_slot(slot),
		.fused_voltage_select_enable(1'b0),
		.fused_hardware_enable_control(1'b0), .fused_safe_state_mode(1'b0),
		.run_state(run_st), .standby_state(stby_st), .power_up_load(pul),
		.processor_reset_ready(rdy), .regulator_enabled(ena),
		.overvoltage_live_status(ov), .undervoltage_live_status('0),
		.fault_events(ev), .below_input_undervoltage_threshold(below),
		.voltage_select_pin(sel_pin), .secondary_enable_pin(en_pin),
		.power_good_pin_o(), .power_good_pin_oe(pg_oe),
		.safety_output_n_o(), .safety_output_n_oe(so_oe),
		.secondary_voltage_code(code),
		.secondary_linear_regulator_en(ldo_en), .fault_protection_req(prot));

	host u_host (
		.sys_clk(sys_clk), .pg_oe(pg_oe), .so_oe(so_oe),
		.reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .pg_level(pg_level),
		.so_level(so_level));

	// ==========================================================
	// Helpers
	task automatic chk(input logic [DATA_W-1:0] s, input logic [DATA_W-1:0] e);
		total_checks++;
		if (s !== e) begin
			n_errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk

	task automatic step(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : step

	// One-cycle fault event, then time for the flag to show
	task automatic hit(input int b);
		ev[b] <= 1'b1;
		step(1);
		ev <= '0;
		step(3);
	endtask : hit

	task automatic print_verdict();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : print_verdict

	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	// Whole run is a few hundred cycles
	initial begin
		#40000;
		n_errors++;
		print_verdict();
	end

	// ==========================================================
	// Tests
	initial begin
		{rst, mode} = 2'b11;
		{slot, run_st, stby_st, pul, rdy, below, sel_pin, en_pin} = '0;
		{ov, ev} = '0;
		ena = '1;
		step(16);
		rst <= 1'b0;
		step(2);
		chk(pg_level, 1'b0);
		chk(so_level, 1'b1);
		u_host.wr(OFF_GOOD_MEMB, 32'h0000_0003);
		rdy <= 1'b1;
		run_st <= 1'b1;
		step(3);
		chk(pg_level, 1'b1);
		ov <= 11'h001;
		step(3);
		chk(pg_level, 1'b0);
		u_host.rd(OFF_REG_LIVE, d);
		chk(d, 32'h0000_0001);
		ov <= '0;
		step(3);
		chk(pg_level, 1'b1);
		u_host.rd(OFF_REG_LATCH, d);
		chk(d, 32'h0000_0001);
		u_host.rd(OFF_REG_LIVE, d);
		chk(d, 32'h0000_0000);
		ov <= 11'h006;
		ena <= 11'h7FD;
		step(3);
		chk(pg_level, 1'b1);
		ov <= '0;
		for (int i = 0; i < 6; i++) begin
			u_host.wr(OFF_SEC_CTRL, {20'h0, rows[i][19:8]});
			{stby_st, sel_pin, en_pin} <= rows[i][7:5];
			step(4);
			chk(code, rows[i][4:1]);
			chk(ldo_en, rows[i][0]);
			u_host.rd(OFF_PIN_STATUS, d);
			chk(d[1:0], {en_pin, sel_pin});
		end
		stby_st <= 1'b0;
		mode <= 1'b0;
		u_host.wr(OFF_GPO_CTRL, 32'h0000_0001);
		step(2);
		chk(pg_level, 1'b1);
		stby_st <= 1'b1;
		step(2);
		chk(pg_level, 1'b0);
		u_host.wr(OFF_GPO_CTRL, 32'h0000_0002);
		step(2);
		chk(pg_level, 1'b1);
		for (int i = 1; i >= 0; i--) begin
			slot <= i[0];
			pul <= 1'b1;
			step(1);
			pul <= 1'b0;
			u_host.rd(OFF_GPO_CTRL, d);
			chk(d, {30'h0, i[0], i[0]});
		end
		u_host.wr(OFF_SAFE_SEL, 32'h0000_000F);
		for (int i = 0; i < 4; i++) begin
			hit(evb[i]);
			chk(so_level, 1'b0);
			u_host.rd(OFF_SAFE_FLAGS, d);
			chk(d, 32'h1 << i);
			u_host.wr(OFF_SAFE_FLAGS, 32'h1 << i);
			step(2);
			chk(so_level, 1'b1);
		end
		u_host.wr(OFF_SAFE_SEL, 32'h0000_0000);
		hit(0);
		chk(so_level, 1'b1);
		u_host.wr(OFF_SAFE_SEL, 32'h0000_0008);
		u_host.wr(OFF_SEC_CTRL, 32'h0000_1000);
		hit(4);
		u_host.wr(OFF_SAFE_FLAGS, 32'h0000_0008);
		step(2);
		chk(so_level, 1'b0);
		u_host.secure_clear(32'h0000_0008);
		step(2);
		chk(so_level, 1'b1);
		hit(1);
		chk(so_level, 1'b0);
		below <= 1'b1;
		step(2);
		chk(so_level, 1'b1);
		// Leave run, then unmask with a member out of regulation
		{mode, run_st, stby_st} <= 3'b100;
		ov <= 11'h001;
		step(1);
		run_st <= 1'b1;
		step(1);
		// Protection request stands one cycle: look mid-cycle
		@(negedge sys_clk);
		chk(prot, 1'b1);
		chk(pg_level, 1'b0);
		print_verdict();
	end
endmodule : test_pmic_aux_pin_control
